/* rtl/store_regs.svh */
// Offsets, field positions and constants of the shared ROM/log store.
// Assumes an 8-bit byte address on the register port.
`ifndef STORE_REGS_SVH
`define STORE_REGS_SVH
`define OFF_AUTORESP_AREA  8'h8C
`define OFF_STATUS_BLOCKS  8'h94
`define OFF_PAGE_TABLES    8'h98
`define OFF_ROM_LENGTHS    8'hF0
`define OFF_LOG_ENABLE     8'hF4
`define OFF_LOG_ROM_CTRL   8'hF8
`define OFF_LOG_ROM_DATA   8'hFC
`define STORE_QUADLETS     7'h7E
`define SIZE_SUM_LIMIT     10'h07E
`define ROM_BASE_PTR       11'h400
`define QUADLET_STEP       11'h004
`define AUTORESP_MAX_BYTES 9'h1F8
`define TOTAL_ROM_MAX      11'h400
`define LEN_LO_LSB         0
`define LEN_HI_LSB         16
`define CTRL_SELECT_BIT    0
`define CTRL_VALID_BIT     1
`define CTRL_SHORT_BIT     2
`define CTRL_PTR_LSB       8
`define CTRL_FILL_LSB      24
`define CTRL_SIZE_ERR_BIT  31
`define REG_RESET          32'h00000000
`endif

/* rtl/store_pkg.sv */
// Types shared by the ROM/log store modules.
// Assumes store_regs.svh carries every numeric constant.
package store_pkg;
  typedef enum logic [1:0] {RESP_DATA, RESP_TARDY, RESP_HOST} resp_code_type;
  typedef enum logic [1:0] {KIND_HEADER, KIND_PAYLOAD, KIND_TRAILER}
    log_kind_type;
endpackage

/* rtl/store_port_if.sv */
// One write port and two read ports of the shared quadlet store.
// Assumes the user drives addresses in the same clock as the store.
`timescale 1ns/1ps
interface store_port_if;
  logic        we;
  logic [6:0]  waddr;
  logic [31:0] wdata;
  logic [6:0]  raddr_a;
  logic [31:0] rdata_a;
  logic [6:0]  raddr_b;
  logic [31:0] rdata_b;
  modport store (input we, waddr, wdata, raddr_a, raddr_b,
                 output rdata_a, rdata_b);
  modport user (output we, waddr, wdata, raddr_a, raddr_b,
                input rdata_a, rdata_b);
endinterface // store_port_if

/* rtl/quadlet_store.sv */
// 126-quadlet shared buffer with one write and two combinational reads.
// Assumes the user keeps addresses below 126; others read as zero.
`timescale 1ns/1ps
`include "store_regs.svh"
module quadlet_store (
  input wire logic    clk,
  store_port_if.store port
);
  logic [31:0] mem [0:125];

  // Reads outside the array answer zero instead of X
  assign port.rdata_a = (port.raddr_a < `STORE_QUADLETS) ?
                        mem[port.raddr_a] : 32'h00000000;
  assign port.rdata_b = (port.raddr_b < `STORE_QUADLETS) ?
                        mem[port.raddr_b] : 32'h00000000;

  // Data array holds no reset, contents survive a soft reset
  always_ff @(posedge clk) begin
    if (port.we && port.waddr < `STORE_QUADLETS) begin
      mem[port.waddr] <= port.wdata;
    end
  end
endmodule // quadlet_store

/* rtl/log_ring.sv */
// Head, tail and fill count of the circular log area.
// Assumes the caller never pops an empty ring.
`timescale 1ns/1ps
module log_ring (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic [6:0] len,
  input  wire logic       push,
  input  wire logic       pop,
  output logic      [6:0] head,
  output logic      [6:0] tail,
  output logic      [6:0] count
);
  function automatic logic [6:0] wrap_inc(input logic [6:0] idx,
                                          input logic [6:0] n);
    logic [6:0] nxt;
    nxt = 7'(idx + 7'h01);
    return (nxt >= n) ? 7'h00 : nxt;
  endfunction

  logic       full;
  logic [6:0] next_head;
  logic [6:0] next_tail;
  logic [6:0] next_count;

  ////////////////////////////////////////////////////////////////////////////
  // full at length
  assign full       = (count == len);
  assign next_head  = push ? wrap_inc(head, len) : head;
  assign next_tail  = (pop || (push && full)) ? wrap_inc(tail, len) : tail;
  assign next_count = (push && !pop && !full) ? 7'(count + 7'h01) :
                      (pop && !push) ? 7'(count - 7'h01) : count;

  // A size change invalidates every stored record
  always_ff @(posedge clk) begin
    if (rst || clear) begin
      head  <= 7'h00;
      tail  <= 7'h00;
      count <= 7'h00;
    end else begin
      head  <= next_head;
      tail  <= next_tail;
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_fill_grows: assert property (@(posedge clk) disable iff (rst)
    push && !pop && !full && !clear |=> count == $past(count) + 7'h01)
    else $error("fill count did not grow on push");
  a_pop_order: assert property (@(posedge clk) disable iff (rst)
    pop && !clear && tail != 7'h00 && tail + 7'h01 < len
    |=> tail == $past(tail) + 7'h01)
    else $error("tail did not advance in order");
endmodule // log_ring

/* rtl/log_rom_store.sv */
// Shared ConfigROM image and transaction log store of a link controller.
// Assumes a single-cycle strobe register port and one-cycle remote
// ConfigROM read requests from the link core.
//
// Contract
// - The ROM area, both page tables, both status blocks and the log area fill exactly 126 quadlets while all but the log sum to at most 126.
// - Remote ConfigROM reads are answered by the block only below the auto-response length, at most 504 bytes.
// - Each data-port write with ROM access selected advances the pointer and stores one ROM quadlet if the pointer is inside the ROM area.
// - Rewriting the start address lets the host read the stored quadlets back.
// - While ROM valid is clear, every remote ConfigROM read gets ack_tardy.
// - A record is logged only for transactions whose log enable is set.
// - Logged quadlets come out in order through data-port reads.
// - Header-only logging keeps header and trailer quadlets and drops payload.
// - A fill count gives the number of quadlets held in the log.
// - A full log overwrites its oldest entries.
// - A fill count equal to the log length marks a full log.
`timescale 1ns/1ps
`include "store_regs.svh"
module log_rom_store #(
  parameter int LOG_SOURCES = 8
) (
  input  wire logic                           CLK,
  input  wire logic                           SYS_RST,
  input  wire logic [7:0]                     ADDR,
  input  wire logic [31:0]                    WDATA,
  input  wire logic                           WR,
  input  wire logic                           RD,
  output logic      [31:0]                    RDATA,
  input  wire logic                           CFG_REQ,
  input  wire logic [9:0]                     CFG_OFFSET,
  output logic                                CFG_RESP_VALID,
  output logic      [1:0]                     CFG_RESP_CODE,
  output logic      [31:0]                    CFG_RESP_DATA,
  input  wire logic                           LOG_VALID,
  input  wire logic [$clog2(LOG_SOURCES)-1:0] LOG_SOURCE,
  input  wire logic [1:0]                     LOG_KIND,
  input  wire logic [31:0]                    LOG_DATA,
  output logic                                SIZE_ERROR
);
  // Byte offset from the ROM base to a store quadlet index
  function automatic logic [7:0] quad_index(input logic [9:0] byte_off);
    return byte_off[9:2];
  endfunction

  store_port_if port ();

  logic [6:0]             autoresp_area_length;
  logic [6:0]             tx_status_block_length;
  logic [6:0]             rx_status_block_length;
  logic [6:0]             tx_page_table_length;
  logic [6:0]             rx_page_table_length;
  logic [8:0]             autoresp_rom_length;
  logic [10:0]            total_rom_length;
  logic [LOG_SOURCES-1:0] log_enable;
  logic                   rom_access_select;
  logic                   rom_valid_a;
  logic                   header_only_logging;
  logic [10:0]            rom_pointer;
  logic [6:0]             log_head;
  logic [6:0]             log_tail;
  logic [6:0]             log_fill_count;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic hit_area   = (ADDR == `OFF_AUTORESP_AREA);
  wire logic hit_status = (ADDR == `OFF_STATUS_BLOCKS);
  wire logic hit_page   = (ADDR == `OFF_PAGE_TABLES);
  wire logic hit_lens   = (ADDR == `OFF_ROM_LENGTHS);
  wire logic hit_enable = (ADDR == `OFF_LOG_ENABLE);
  wire logic hit_ctrl   = (ADDR == `OFF_LOG_ROM_CTRL);
  wire logic hit_data   = (ADDR == `OFF_LOG_ROM_DATA);
  wire logic size_write = WR && (hit_area || hit_status || hit_page);
  wire logic data_wr    = WR && hit_data;
  wire logic data_rd    = RD && hit_data;

  ////////////////////////////////////////////////////////////////////////////
  // area partition, the log gets whatever the other areas leave
  wire logic [9:0] others_sum = 10'(autoresp_area_length)
    + 10'(tx_status_block_length) + 10'(rx_status_block_length)
    + 10'(tx_page_table_length) + 10'(rx_page_table_length);
  wire logic       size_bad = (others_sum > `SIZE_SUM_LIMIT);
  wire logic [6:0] log_area_length = size_bad ? 7'h00 :
                   7'(`STORE_QUADLETS - others_sum[6:0]);
  wire logic [6:0] log_base = others_sum[6:0];

  ////////////////////////////////////////////////////////////////////////////
  // ROM pointer to quadlet index; only the base window reaches the store
  wire logic [7:0] rom_idx     = quad_index(rom_pointer[9:0]);
  // Remote read offset to quadlet index, needed by the store port below
  wire logic [7:0] cfg_idx     = quad_index(CFG_OFFSET);
  wire logic       rom_in_area = rom_pointer[10] &&
                                 (rom_idx < 8'(autoresp_area_length));
  wire logic rom_write = data_wr && rom_access_select && rom_in_area;
  wire logic rom_step  = (data_wr || data_rd) && rom_access_select;

  ////////////////////////////////////////////////////////////////////////////
  // enable gate
  wire logic source_on = log_enable[LOG_SOURCE];
  wire logic kind_kept = !(header_only_logging &&
                           LOG_KIND == 2'(store_pkg::KIND_PAYLOAD));
  // Host ROM writes own the write port, a colliding log quadlet is lost
  wire logic log_push = LOG_VALID && source_on && kind_kept &&
                        !rom_write && (log_area_length != 7'h00);
  wire logic log_pop  = data_rd && !rom_access_select &&
                        (log_fill_count != 7'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Store port selection
  assign port.we      = rom_write || log_push;
  assign port.waddr   = rom_write ? rom_idx[6:0] : 7'(log_base + log_head);
  assign port.wdata   = rom_write ? WDATA : LOG_DATA;
  assign port.raddr_a = rom_access_select ? rom_idx[6:0] :
                        7'(log_base + log_tail);
  assign port.raddr_b = cfg_idx[6:0];

  // readback, out-of-area pointer or empty log reads zero
  wire logic [31:0] data_word =
    (rom_access_select ? rom_in_area : log_fill_count != 7'h00) ?
    port.rdata_a : 32'h00000000;
  wire logic [31:0] ctrl_word = {size_bad, log_fill_count, 5'h00,
    rom_pointer, 5'h00, header_only_logging, rom_valid_a,
    rom_access_select};
  wire logic [31:0] next_rdata =
    hit_area   ? 32'(autoresp_area_length) :
    hit_status ? {9'h000, rx_status_block_length, 9'h000,
                  tx_status_block_length} :
    hit_page   ? {9'h000, rx_page_table_length, 9'h000,
                  tx_page_table_length} :
    hit_lens   ? {5'h00, total_rom_length, 7'h00, autoresp_rom_length} :
    hit_enable ? 32'(log_enable) :
    hit_ctrl   ? ctrl_word :
    hit_data   ? data_word : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // auto-response window, also bounded by the programmed ROM area
  wire logic cfg_auto = (CFG_OFFSET < 10'(autoresp_rom_length)) &&
                        (cfg_idx < 8'(autoresp_area_length));
  // tardy until valid; the rest goes to the host
  wire logic [1:0] next_code =
    !rom_valid_a ? 2'(store_pkg::RESP_TARDY) :
    cfg_auto     ? 2'(store_pkg::RESP_DATA) : 2'(store_pkg::RESP_HOST);

  quadlet_store u_store (
    .clk  (CLK),
    .port (port.store)
  );

  log_ring u_ring (
    .clk   (CLK),
    .rst   (SYS_RST),
    .clear (size_write),
    .len   (log_area_length),
    .push  (log_push),
    .pop   (log_pop),
    .head  (log_head),
    .tail  (log_tail),
    .count (log_fill_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Size registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      autoresp_area_length   <= 7'h00;
      tx_status_block_length <= 7'h00;
      rx_status_block_length <= 7'h00;
      tx_page_table_length   <= 7'h00;
      rx_page_table_length   <= 7'h00;
    end else if (WR) begin
      if (hit_area) autoresp_area_length <= WDATA[`LEN_LO_LSB +: 7];
      if (hit_status) begin
        tx_status_block_length <= WDATA[`LEN_LO_LSB +: 7];
        rx_status_block_length <= WDATA[`LEN_HI_LSB +: 7];
      end
      if (hit_page) begin
        tx_page_table_length <= WDATA[`LEN_LO_LSB +: 7];
        rx_page_table_length <= WDATA[`LEN_HI_LSB +: 7];
      end
    end
  end

  // lengths clamped to their ceilings here, 504 and 1024 bytes
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      autoresp_rom_length <= 9'h000;
      total_rom_length    <= 11'h000;
      log_enable          <= '0;
    end else if (WR && hit_lens) begin
      autoresp_rom_length <= (WDATA[8:0] > `AUTORESP_MAX_BYTES) ?
                             `AUTORESP_MAX_BYTES : WDATA[8:0];
      total_rom_length    <= (WDATA[26:16] > `TOTAL_ROM_MAX) ?
                             `TOTAL_ROM_MAX : WDATA[26:16];
    end else if (WR && hit_enable) begin
      log_enable <= WDATA[LOG_SOURCES-1:0];
    end
  end

  // select and pointer load; one write ends loading
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rom_access_select   <= 1'b0;
      rom_valid_a         <= 1'b0;
      header_only_logging <= 1'b0;
      rom_pointer         <= `ROM_BASE_PTR;
    end else if (WR && hit_ctrl) begin
      rom_access_select   <= WDATA[`CTRL_SELECT_BIT];
      rom_valid_a         <= WDATA[`CTRL_VALID_BIT];
      header_only_logging <= WDATA[`CTRL_SHORT_BIT];
      rom_pointer         <= WDATA[`CTRL_PTR_LSB +: 11];
    end else if (rom_step) begin
      rom_pointer <= 11'(rom_pointer + `QUADLET_STEP);
    end
  end

  // Registered answers, read data only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      RDATA          <= `REG_RESET;
      CFG_RESP_VALID <= 1'b0;
      CFG_RESP_CODE  <= 2'h0;
      CFG_RESP_DATA  <= `REG_RESET;
      SIZE_ERROR     <= 1'b0;
    end else begin
      RDATA          <= RD ? next_rdata : 32'h00000000;
      CFG_RESP_VALID <= CFG_REQ;
      CFG_RESP_CODE  <= CFG_REQ ? next_code : 2'h0;
      CFG_RESP_DATA  <= (CFG_REQ && next_code == 2'(store_pkg::RESP_DATA))
                        ? port.rdata_b : 32'h00000000;
      SIZE_ERROR     <= size_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_tardy_invalid: assert property (
    CFG_REQ && !rom_valid_a |=> CFG_RESP_VALID &&
    CFG_RESP_CODE == 2'(store_pkg::RESP_TARDY))
    else $error("invalid ROM read not tardy");
  a_autoresp_range: assert property (
    CFG_REQ && CFG_OFFSET >= 10'(autoresp_rom_length)
    |=> CFG_RESP_CODE != 2'(store_pkg::RESP_DATA))
    else $error("data answered beyond auto-response length");
  a_host_forward: assert property (
    CFG_REQ && rom_valid_a && !cfg_auto
    |=> CFG_RESP_CODE == 2'(store_pkg::RESP_HOST))
    else $error("upper ROM read not left to host");
  a_rom_store: assert property (
    data_wr && rom_access_select && rom_in_area
    |-> port.we && port.waddr == rom_idx[6:0] && port.wdata == WDATA)
    else $error("ROM quadlet not written");
  a_pointer_step: assert property (
    rom_step |=> rom_pointer == 11'($past(rom_pointer) + `QUADLET_STEP))
    else $error("ROM pointer did not step by four");
  a_verify_read: assert property (
    data_rd && rom_access_select && rom_in_area
    |=> RDATA == $past(port.rdata_a))
    else $error("ROM readback mismatch");
  a_enable_gate: assert property (
    LOG_VALID && !source_on && !size_write
    |=> log_fill_count <= $past(log_fill_count))
    else $error("disabled transaction logged");
  a_short_drop: assert property (
    LOG_VALID && header_only_logging && !log_pop && !size_write &&
    LOG_KIND == 2'(store_pkg::KIND_PAYLOAD)
    |=> log_fill_count == $past(log_fill_count))
    else $error("payload logged in header-only mode");
  a_fill_bound: assert property (
    log_fill_count <= log_area_length || $past(size_write))
    else $error("fill count above log length");
  a_full_overwrite: assert property (
    log_push && !log_pop && !size_write &&
    log_fill_count == log_area_length
    |=> log_fill_count == $past(log_fill_count) &&
        log_tail != $past(log_tail) || log_area_length == 7'h01)
    else $error("full log did not overwrite oldest");
  a_size_flag: assert property (
    size_write ##1 !size_write
    |=> SIZE_ERROR == (others_sum > `SIZE_SUM_LIMIT))
    else $error("size error flag wrong");

  c_rom_load: cover property (
    data_wr && rom_access_select ##1 data_wr && rom_access_select);
  c_rom_served: cover property (
    CFG_REQ ##1 CFG_RESP_CODE == 2'(store_pkg::RESP_DATA));
  c_log_full: cover property (
    log_push && log_fill_count == log_area_length &&
    log_area_length != 7'h00);
  c_log_read: cover property (log_pop ##1 log_pop);
endmodule // log_rom_store

/* verification/record_source.sv */
// Remote traffic source: one logged record per start pulse.
// Assumes the store takes a quadlet every cycle, no back-pressure.
`timescale 1ns/1ps
module record_source (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [2:0]  src,
  input  wire logic [3:0]  pay_n,
  input  wire logic [23:0] tag_base,
  output logic             valid,
  output logic [2:0]       source,
  output logic [1:0]       kind,
  output logic [31:0]      data,
  output logic             busy
);
  logic [4:0] idx;
  logic       last;

  assign last = idx > {1'b0, pay_n};

  initial begin
    busy = 1'b0;
    data = 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Header, payloads, trailer back to back; idle data toggles so a
  // stale quadlet can never pass for a fresh one
  always @(posedge clk) begin
    valid <= 1'b0;
    data  <= ~data;
    if (start) begin
      busy <= 1'b1;
      idx  <= 5'h00;
    end else if (busy) begin
      valid  <= 1'b1;
      source <= src;
      data   <= {tag_base, 3'h0, idx};
      kind   <= (idx == 5'h00) ? store_pkg::KIND_HEADER :
                (last ? store_pkg::KIND_TRAILER : store_pkg::KIND_PAYLOAD);
      idx    <= idx + 5'h01;
      if (last) begin
        busy <= 1'b0;
      end
    end
  end
endmodule // record_source

/* verification/tb_log_rom_store.sv */
// Self-checking bench of the shared ROM/log store.
// Assumes register and remote-read answers one cycle after the strobe.
`timescale 1ns/1ps
module tb_log_rom_store;
  typedef struct {logic [31:0] e; logic [31:0] m;} note_type;
  logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
  logic        cfg = 1'b0, start = 1'b0, rd_seen = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, cdata, ldata;
  logic [9:0]  coff = 10'h000;
  logic [1:0]  ccode, lkind;
  logic [2:0]  src = 3'h0, lsrc;
  logic [3:0]  pay_n = 4'h0;
  logic [23:0] tb_base = 24'h000000;
  logic        cvalid, lvalid, sbusy, size_err;
  logic [31:0] rom [0:7];
  logic [23:0] ba, bc;
  note_type    rd_q[$], cfg_q[$], n;
  int          err_total = 0, checks_done = 0, cycles = 0, j, k;

  log_rom_store dut (.CLK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .CFG_REQ(cfg), .CFG_OFFSET(coff),
    .CFG_RESP_VALID(cvalid), .CFG_RESP_CODE(ccode), .CFG_RESP_DATA(cdata),
    .LOG_VALID(lvalid), .LOG_SOURCE(lsrc), .LOG_KIND(lkind),
    .LOG_DATA(ldata), .SIZE_ERROR(size_err));

  record_source peer (.clk(clk), .start(start), .src(src), .pay_n(pay_n),
    .tag_base(tb_base), .valid(lvalid), .source(lsrc), .kind(lkind),
    .data(ldata), .busy(sbusy));

  always #5 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One bus cycle; every strobe is set each call so none is driven twice
  task automatic bus(input logic w, r, c, input logic [7:0] a,
                     input logic [31:0] d);
    wr_s  <= w;
    rd_s  <= r;
    cfg   <= c;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    rd_q.push_back('{e, m});
    bus(1'b0, 1'b1, 1'b0, a, 32'h00000000);
  endtask

  task automatic creq(input logic [9:0] o, input logic [1:0] code,
                      input logic [31:0] d);
    cfg_q.push_back('{{30'h0, code}, d});
    coff <= o;
    bus(1'b0, 1'b0, 1'b1, 8'h00, 32'h00000000);
  endtask

  task automatic idle;
    bus(1'b0, 1'b0, 1'b0, 8'h00, 32'h00000000);
  endtask

  // Far side sends one record, then the bus waits for it to finish
  task automatic send(input logic [2:0] s, input logic [3:0] p,
                      input logic [23:0] b);
    idle();
    src     <= s;
    pay_n   <= p;
    tb_base <= b;
    start   <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (sbusy)
      @(posedge clk);
    @(posedge clk);
  endtask

  function automatic logic [31:0] q(input logic [23:0] b, input int i);
    return {b, 3'h0, 5'(i)};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Answers are matched to the oldest note; masks hide unchecked fields
  always @(posedge clk) begin
    rd_seen <= rd_s;
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
    if (rd_seen && rd_q.size() > 0) begin
      n = rd_q.pop_front();
      check("rdata", rdata & n.m, n.e);
    end else if (!rst && !rd_seen) begin
      // Read data stands one cycle only, zero otherwise
      check("rdata_idle", rdata, 32'h00000000);
    end
    if (cvalid && cfg_q.size() > 0) begin
      n = cfg_q.pop_front();
      check("cfg_code", {30'h0, ccode}, n.e);
      check("cfg_data", cdata, n.m);
    end else if (!rst) begin
      // An answer with no request behind it is a fault
      check("cfg_valid", {31'h0, cvalid}, 32'h0);
    end
  end

  initial begin
    void'($urandom(32'h8855));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'hF8, 32'h00040000, 32'hFFFFFFFF);
    rd(8'h8C, 32'h00000000, 32'hFFFFFFFF);
    rd(8'h10, 32'h00000000, 32'hFFFFFFFF);
    creq(10'h000, store_pkg::RESP_TARDY, 32'h0);
    $display("test reset done");
    // Sizes over the limit, then a six-quadlet log area
    wr(8'h8C, 32'h00000008);
    wr(8'h94, 32'h00320032);
    wr(8'h98, 32'h000A000A);
    idle();
    idle();
    check("size_error", {31'h0, size_err}, 32'h1);
    wr(8'h98, 32'h00060006);
    idle();
    idle();
    check("size_error", {31'h0, size_err}, 32'h0);
    wr(8'hF0, 32'h07FF01FF);
    rd(8'hF0, 32'h040001F8, 32'hFFFFFFFF);
    wr(8'hF0, 32'h00200010);
    rd(8'hF0, 32'h00200010, 32'hFFFFFFFF);
    $display("test sizes done");
    // Load eight quadlets plus one beyond the area
    wr(8'hF8, 32'h00040001);
    for (j = 0; j < 8; j++) begin
      rom[j] = $urandom;
      wr(8'hFC, rom[j]);
    end
    wr(8'hFC, 32'hDEADBEEF);
    rd(8'hF8, 32'h00042401, 32'h0007FFFF);
    wr(8'hF8, 32'h00040001);
    for (j = 0; j < 9; j++)
      rd(8'hFC, (j < 8) ? rom[j] : 32'h0, 32'hFFFFFFFF);
    wr(8'hF8, 32'h00000002);
    for (j = 0; j < 4; j++) begin
      k = $urandom_range(3, 0);
      creq(10'(k * 4), store_pkg::RESP_DATA, rom[k]);
    end
    $display("test rom done");
    ba = 24'($urandom);
    bc = ~ba;
    wr(8'hF4, 32'h00000004);
    // Source 2 logs; one read at the auto length, one inside it
    creq(10'h010, store_pkg::RESP_HOST, 32'h0);
    creq(10'h00C, store_pkg::RESP_DATA, rom[3]);
    send(3'h2, 4'h2, ba);
    send(3'h3, 4'h1, 24'h123456);
    rd(8'hF8, 32'h04000000, 32'h7F000000);
    send(3'h2, 4'h2, bc);
    rd(8'hF8, 32'h06000000, 32'h7F000000);
    rd(8'hFC, q(ba, 2), 32'hFFFFFFFF);
    rd(8'hFC, q(ba, 3), 32'hFFFFFFFF);
    for (j = 0; j < 4; j++)
      rd(8'hFC, q(bc, j), 32'hFFFFFFFF);
    rd(8'hFC, 32'h00000000, 32'hFFFFFFFF);
    $display("test wrap done");
    wr(8'hF8, 32'h00000006);
    send(3'h2, 4'h3, ba);
    rd(8'hF8, 32'h02000000, 32'h7F000000);
    rd(8'hFC, q(ba, 0), 32'hFFFFFFFF);
    rd(8'hFC, q(ba, 4), 32'hFFFFFFFF);
    idle();
    idle();
    idle();
    check("pending", 32'(rd_q.size() + cfg_q.size()), 32'h0);
    $display("test log done");
    wrap_up();
  end
endmodule // tb_log_rom_store
